/* File: logic/spc_defs.svh */
// Constants for the serial parameter command interpreter
// Function
// - Panel baud choice offers nine rates, 75 up to 19200.
// - Standalone baud comes from dial; positions 8 and 9 both give 19200.
// - Standalone framing is fixed at 8 data bits, no parity, 1 stop bit.
// - After a panel baud entry with display attached, the dial is ignored.
// - Panel cancel drops pending changes and keeps previous settings.
// - Valid setting code applies its setting and answers PASS CR.
// - Measurement or information output codes get no PASS reply.
// - 20H auto gain, 21H-24H gains 1-4; 25H-28H normal, p-p, peak, bottom.
// - 29H-3AH set averaging count 1 to 131072, doubling per code.
// - 3BH-42H switch auto-zero, hold, key lock, filter; odd on, even off.
// - Key lock ignores panel key input and lights lock indicator.
// - 43H-4AH select limits, 65H-6CH parameters, 6DH filter value.
// - Accept calibration 0.9000-1.1000, intensity 0-49998, filter 100-4999.
// - Limit and offset values are reported with an explicit sign.
// - Out of range value is rejected with ERROR CR.
// - Add or subtract selected refuses calibration, intensity limits and gain.
// - Filter changes only allowed with display attached.
// - Transmit only while terminal ready input is high; unconnected means high (dtr here is a plain wire input with no pull-up).
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH
`define SPC_CLK_HZ 32'h0262_5A00
`define SPC_BAUD_BASE 32'h0000_004B
`define SPC_BAUD_MAX 4'h8
`define SPC_BAUD_RST 8'h04
`define SPC_A_CTRL 8'h00
`define SPC_A_PANEL 8'h04
`define SPC_A_SET 8'h08
`define SPC_A_STAT 8'h0C
`define SPC_A_VAL 8'h40
`define SPC_A_VLAST 8'h80
`define SPC_PAN_COMMIT 8
`define SPC_PAN_CANCEL 9
`define SPC_C_GAIN_LO 8'h20
`define SPC_C_GAIN_HI 8'h24
`define SPC_C_MODE_LO 8'h25
`define SPC_C_MODE_HI 8'h28
`define SPC_C_AVG_LO 8'h29
`define SPC_C_AVG_HI 8'h3A
`define SPC_C_SW_LO 8'h3B
`define SPC_C_LOCK_ON 8'h3F
`define SPC_C_FILT_ON 8'h41
`define SPC_C_SW_HI 8'h42
`define SPC_C_LIM_LO 8'h43
`define SPC_C_LIM_HI 8'h4A
`define SPC_C_OUT_LO 8'h4D
`define SPC_C_OUT_HI 8'h64
`define SPC_C_PAR_LO 8'h65
`define SPC_C_FILT_VAL 8'h6D
`define SPC_C_SEL_LO 8'h6E
`define SPC_C_SEL_ADD 8'h70
`define SPC_C_SEL_HI 8'h71
`define SPC_CH_CR 8'h0D
`define SPC_CH_0 8'h30
`define SPC_CH_9 8'h39
`define SPC_CH_MINUS 8'h2D
`define SPC_CAL_MIN 24'h00_2328
`define SPC_CAL_MAX 24'h00_2AF8
`define SPC_INT_MAX 24'h00_C34E
`define SPC_TIME_MAX 24'h00_752F
`define SPC_TIME_INF 24'h01_869F
`define SPC_RATIO_MAX 24'h00_0005
`define SPC_SUPP_MAX 24'h00_0004
`define SPC_FILT_MIN 24'h00_0064
`define SPC_FILT_MAX 24'h00_1387
`define SPC_ACC_LIM 24'h19_9999
`define SPC_PASS_LAST 3'h4
`define SPC_ERR_LAST 3'h5
`endif

/* File: logic/spc_pkg.sv */
// Types and helpers for the serial parameter command interpreter
`include "spc_defs.svh"
package spc_pkg;
  typedef struct packed {
    logic seven;
    logic par_en;
    logic par_odd;
    logic two_stop;
  } spc_frame_t;
  typedef enum logic [0:0] {ST_CMD = 1'b0, ST_VAL = 1'b1} spc_state_t;
  typedef enum logic [0:0] {RP_PASS = 1'b0, RP_ERROR = 1'b1} spc_reply_t;
  function automatic logic [19:0] spc_baud_div(input int unsigned clk_hz, input logic [3:0] idx);
    int unsigned rate;
    rate = `SPC_BAUD_BASE << idx;
    return 20'(clk_hz / rate);
  endfunction: spc_baud_div
endpackage: spc_pkg

/* File: logic/spc_ser_if.sv */
// Link between command logic and serial transmitter and receiver
`timescale 1ns/10ps
interface spc_ser_if;
  import spc_pkg::*;
  logic [19:0] div;
  spc_frame_t frame;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  modport ctl(output div, frame, tx_data, tx_valid, input rx_data, rx_valid, tx_ready);
  modport rx(input div, frame, output rx_data, rx_valid);
  modport tx(input div, frame, tx_data, tx_valid, output tx_ready);
endinterface: spc_ser_if

/* File: logic/spc_top.sv */
// Serial parameter command interpreter with APB register slave
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "spc_defs.svh"
module spc_top
  import spc_pkg::*;
#(
  parameter int unsigned CLK_HZ = `SPC_CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  input wire logic dtr,
  input wire logic [3:0] baud_dial,
  output logic lock_led
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] dial_map(input logic [3:0] d);
    return (d > `SPC_BAUD_MAX) ? `SPC_BAUD_MAX : d;
  endfunction: dial_map

  function automatic logic range_ok(input logic [4:0] it, input logic ng, input logic [23:0] v, input logic ov);
    logic ok;
    ok = !ov;
    unique case (it)
      5'd9: ok = ok && !ng && v >= `SPC_CAL_MIN && v <= `SPC_CAL_MAX;
      5'd10, 5'd12: ok = ok && !ng && v <= `SPC_INT_MAX;
      5'd11, 5'd13: ok = ok && !ng && (v <= `SPC_TIME_MAX || v == `SPC_TIME_INF);
      5'd14: ok = ok && !ng && v <= `SPC_RATIO_MAX;
      5'd15: ok = ok && !ng && v <= `SPC_SUPP_MAX;
      5'd16: ok = ok && !ng && v >= `SPC_FILT_MIN && v <= `SPC_FILT_MAX;
      default: ok = ok;
    endcase
    return ok;
  endfunction: range_ok

  // Reply text, PASS CR or ERROR CR
  function automatic logic [7:0] reply_char(input spc_reply_t k, input logic [2:0] i);
    logic [7:0] c;
    c = `SPC_CH_CR;
    if (k == RP_PASS) begin
      unique case (i)
        3'd0: c = 8'h50;
        3'd1: c = 8'h41;
        3'd2, 3'd3: c = 8'h53;
        default: c = `SPC_CH_CR;
      endcase
    end else begin
      unique case (i)
        3'd0: c = 8'h45;
        3'd1, 3'd2, 3'd4: c = 8'h52;
        3'd3: c = 8'h4F;
        default: c = `SPC_CH_CR;
      endcase
    end
    return c;
  endfunction: reply_char

  spc_ser_if ser();
  spc_uart_rx u_rx (.pclk(pclk), .presetn(presetn), .rxd(rxd), .ser(ser.rx));
  spc_uart_tx u_tx (.pclk(pclk), .presetn(presetn), .ser(ser.tx), .txd(txd));

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic disp_r, disp_nxt, pset_r, pset_nxt;
  logic [7:0] pend_r, pend_nxt, act_r, act_nxt;
  logic [3:0] baud_idx_r, baud_idx_nxt, act_baud;
  spc_frame_t frame_r, frame_nxt;
  logic [19:0] div_r, div_nxt;
  spc_state_t st_r, st_nxt;
  logic [2:0] gain_r, gain_nxt;
  logic [1:0] mode_r, mode_nxt, sel_r, sel_nxt;
  logic [4:0] avg_r, avg_nxt, item_r, item_nxt;
  logic az_r, az_nxt, hold_r, hold_nxt, lock_r, lock_nxt, filt_r, filt_nxt;
  logic sel_ok_r, sel_ok_nxt, addsub_r, addsub_nxt, neg_r, neg_nxt, ovf_r, ovf_nxt;
  logic [23:0] acc_r, acc_nxt;
  logic rq_r, rq_nxt;
  spc_reply_t rq_kind_r, rq_kind_nxt;
  logic [24:0] val_mem [0:16];
  logic val_we;
  logic [24:0] val_wd;
  logic rp_busy_r, rp_busy_nxt, rp_pend_r, rp_pend_nxt;
  spc_reply_t rp_kind_r, rp_kind_nxt, rp_pkind_r, rp_pkind_nxt;
  logic [2:0] rp_idx_r, rp_idx_nxt;
  logic acc_ph, done, map_ok, in_val, pan_wr, pan_cancel, cmd_rx;
  logic [4:0] vi;
  logic [7:0] b, pw8;

  // ----------------------------------------
  // APB slave and serial configuration
  // ----------------------------------------
  assign acc_ph = psel && penable;
  assign done = acc_ph && pready_r;
  assign vi = 5'((paddr - `SPC_A_VAL) >> 2);
  assign in_val = paddr >= `SPC_A_VAL && paddr <= `SPC_A_VLAST;
  assign map_ok = paddr[1:0] == 2'b00 && (paddr == `SPC_A_CTRL || paddr == `SPC_A_PANEL ||
                  (!pwrite && (paddr == `SPC_A_SET || paddr == `SPC_A_STAT || in_val)));
  assign pan_wr = done && pwrite && paddr == `SPC_A_PANEL && disp_r;
  assign pan_cancel = pan_wr && !lock_r && pwdata[`SPC_PAN_CANCEL];
  assign act_baud = act_r[3:0];
  assign pw8 = {pwdata[7:4], dial_map(pwdata[3:0])};

  always_comb begin
    pready_nxt = acc_ph && !pready_r;
    pslverr_nxt = acc_ph && !pready_r && !map_ok;
    prdata_nxt = 32'h0000_0000;
    {disp_nxt, pset_nxt, pend_nxt, act_nxt} = {disp_r, pset_r, pend_r, act_r};
    if (acc_ph && !pready_r && map_ok && !pwrite) begin
      if (paddr == `SPC_A_CTRL) prdata_nxt = {31'd0, disp_r};
      else if (paddr == `SPC_A_PANEL) prdata_nxt = {24'd0, pend_r};
      else if (paddr == `SPC_A_SET)
        prdata_nxt = {7'd0, baud_idx_r, frame_r, addsub_r, sel_r, filt_r, lock_r, hold_r, az_r, avg_r, mode_r, gain_r};
      else if (paddr == `SPC_A_STAT) prdata_nxt = {27'd0, st_r, rp_busy_r, pset_r, sel_ok_r, dtr};
      else prdata_nxt = {val_mem[vi][24], 7'd0, val_mem[vi][23:0]};
    end
    if (done && pwrite && map_ok && paddr == `SPC_A_CTRL) disp_nxt = pwdata[0];
    if (pan_wr && !lock_r) begin
      if (pwdata[`SPC_PAN_CANCEL]) begin
        pend_nxt = act_r;
      end else begin
        pend_nxt = pw8;
        if (pwdata[`SPC_PAN_COMMIT]) begin
          act_nxt = pw8;
          pset_nxt = 1'b1;
        end
      end
    end
    if (disp_r && pset_r) baud_idx_nxt = act_baud;
    else baud_idx_nxt = dial_map(baud_dial);
    frame_nxt = disp_r ? spc_frame_t'(act_r[7:4]) : spc_frame_t'(4'h0);
    div_nxt = spc_baud_div(CLK_HZ, baud_idx_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pready_r, pslverr_r, prdata_r, disp_r, pset_r} <= '0;
      pend_r <= `SPC_BAUD_RST;
      act_r <= `SPC_BAUD_RST;
      baud_idx_r <= 4'(`SPC_BAUD_RST);
      frame_r <= '0;
      div_r <= '0;
    end else begin
      {pready_r, pslverr_r, prdata_r} <= {pready_nxt, pslverr_nxt, prdata_nxt};
      {disp_r, pset_r, pend_r, act_r} <= {disp_nxt, pset_nxt, pend_nxt, act_nxt};
      {baud_idx_r, frame_r, div_r} <= {baud_idx_nxt, frame_nxt, div_nxt};
    end
  end

  assign ser.div = div_r;
  assign ser.frame = frame_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign lock_led = lock_r;

  // ----------------------------------------
  // Command parser and settings
  // ----------------------------------------
  assign b = ser.rx_data;
  assign cmd_rx = st_r == ST_CMD && ser.rx_valid;

  always_comb begin
    {st_nxt, gain_nxt, mode_nxt, avg_nxt, az_nxt, hold_nxt, lock_nxt, filt_nxt} =
      {st_r, gain_r, mode_r, avg_r, az_r, hold_r, lock_r, filt_r};
    {sel_nxt, sel_ok_nxt, addsub_nxt, item_nxt, neg_nxt, acc_nxt, ovf_nxt} =
      {sel_r, sel_ok_r, addsub_r, item_r, neg_r, acc_r, ovf_r};
    rq_nxt = 1'b0;
    rq_kind_nxt = rq_kind_r;
    val_we = 1'b0;
    val_wd = {neg_r, acc_r};
    if (ser.rx_valid) begin
      unique case (st_r)
        ST_CMD: begin
          if (b >= `SPC_C_GAIN_LO && b <= `SPC_C_GAIN_HI) begin
            rq_nxt = 1'b1;
            rq_kind_nxt = RP_ERROR;
            if (!addsub_r) begin
              gain_nxt = 3'(b - `SPC_C_GAIN_LO);
              rq_kind_nxt = RP_PASS;
            end
          end else if (b >= `SPC_C_MODE_LO && b <= `SPC_C_MODE_HI) begin
            mode_nxt = 2'(b - `SPC_C_MODE_LO);
            rq_nxt = 1'b1;
            rq_kind_nxt = RP_PASS;
          end else if (b >= `SPC_C_AVG_LO && b <= `SPC_C_AVG_HI) begin
            avg_nxt = 5'(b - `SPC_C_AVG_LO);
            rq_nxt = 1'b1;
            rq_kind_nxt = RP_PASS;
          end else if (b >= `SPC_C_SW_LO && b <= `SPC_C_SW_HI) begin
            rq_nxt = 1'b1;
            rq_kind_nxt = RP_PASS;
            if (b < `SPC_C_SW_LO + 8'h02) az_nxt = b[0];
            else if (b < `SPC_C_LOCK_ON) hold_nxt = b[0];
            else if (b < `SPC_C_FILT_ON) lock_nxt = b[0];
            else if (disp_r) filt_nxt = b[0];
            else rq_kind_nxt = RP_ERROR;
          end else if (b >= `SPC_C_SEL_LO && b <= `SPC_C_SEL_HI) begin
            sel_nxt = 2'(b - `SPC_C_SEL_LO);
            sel_ok_nxt = 1'b1;
            addsub_nxt = b >= `SPC_C_SEL_ADD;
            rq_nxt = 1'b1;
            rq_kind_nxt = RP_PASS;
          end else if ((b >= `SPC_C_LIM_LO && b <= `SPC_C_LIM_HI) ||
                       (b >= `SPC_C_PAR_LO && b <= `SPC_C_FILT_VAL)) begin
            item_nxt = (b <= `SPC_C_LIM_HI) ? 5'(b - `SPC_C_LIM_LO) : 5'(b - `SPC_C_PAR_LO + 8'h08);
            rq_nxt = 1'b1;
            rq_kind_nxt = RP_ERROR;
            if (sel_ok_r && !(addsub_r && item_nxt >= 5'd9 && item_nxt <= 5'd13) &&
                !(item_nxt == 5'd16 && !disp_r)) begin
              rq_kind_nxt = RP_PASS;
              st_nxt = ST_VAL;
              {neg_nxt, acc_nxt, ovf_nxt} = '0;
            end
          end
        end
        ST_VAL: begin
          if (b >= `SPC_CH_0 && b <= `SPC_CH_9) begin
            if (acc_r > `SPC_ACC_LIM || (acc_r == `SPC_ACC_LIM && b > 8'h35)) ovf_nxt = 1'b1;
            acc_nxt = 24'(acc_r * 28'd10 + 28'(b - `SPC_CH_0));
          end else if (b == `SPC_CH_MINUS) begin
            neg_nxt = 1'b1;
          end else if (b == `SPC_CH_CR) begin
            st_nxt = ST_CMD;
            rq_nxt = 1'b1;
            val_we = range_ok(item_r, neg_r, acc_r, ovf_r);
            rq_kind_nxt = val_we ? RP_PASS : RP_ERROR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_CMD;
      {gain_r, mode_r, avg_r, az_r, hold_r, lock_r, filt_r} <= '0;
      {sel_r, sel_ok_r, addsub_r, item_r, neg_r, acc_r, ovf_r, rq_r} <= '0;
      rq_kind_r <= RP_PASS;
      for (int i = 0; i < 17; i++) begin
        val_mem[i] <= '0;
      end
    end else begin
      {st_r, gain_r, mode_r, avg_r, az_r, hold_r, lock_r, filt_r} <=
        {st_nxt, gain_nxt, mode_nxt, avg_nxt, az_nxt, hold_nxt, lock_nxt, filt_nxt};
      {sel_r, sel_ok_r, addsub_r, item_r, neg_r, acc_r, ovf_r, rq_r} <=
        {sel_nxt, sel_ok_nxt, addsub_nxt, item_nxt, neg_nxt, acc_nxt, ovf_nxt, rq_nxt};
      rq_kind_r <= rq_kind_nxt;
      if (val_we) val_mem[item_r] <= val_wd;
    end
  end

  // ----------------------------------------
  // Reply sequencer
  // ----------------------------------------
  // send only with terminal ready
  assign ser.tx_valid = rp_busy_r && dtr;
  assign ser.tx_data = reply_char(rp_kind_r, rp_idx_r);

  always_comb begin
    {rp_busy_nxt, rp_pend_nxt, rp_kind_nxt, rp_pkind_nxt, rp_idx_nxt} =
      {rp_busy_r, rp_pend_r, rp_kind_r, rp_pkind_r, rp_idx_r};
    if (ser.tx_valid && ser.tx_ready) begin
      rp_idx_nxt = rp_idx_r + 3'd1;
      if (rp_idx_r == (rp_kind_r == RP_PASS ? `SPC_PASS_LAST : `SPC_ERR_LAST)) rp_busy_nxt = 1'b0;
    end
    if (rq_r) begin
      rp_pend_nxt = 1'b1;
      rp_pkind_nxt = rq_kind_r;
    end
    if (!rp_busy_nxt && rp_pend_nxt) begin
      rp_busy_nxt = 1'b1;
      rp_kind_nxt = rp_pkind_nxt;
      rp_idx_nxt = 3'd0;
      rp_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rp_busy_r, rp_pend_r, rp_idx_r} <= '0;
      rp_kind_r <= RP_PASS;
      rp_pkind_r <= RP_PASS;
    end else begin
      {rp_busy_r, rp_pend_r, rp_kind_r, rp_pkind_r, rp_idx_r} <=
        {rp_busy_nxt, rp_pend_nxt, rp_kind_nxt, rp_pkind_nxt, rp_idx_nxt};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  baud_range_a: assert property (baud_idx_r <= `SPC_BAUD_MAX)
    else $error("baud index out of range");
  dial_map_a: assert property (presetn && !disp_r |=> baud_idx_r == dial_map($past(baud_dial)))
    else $error("dial baud not followed");
  frame_fixed_a: assert property (!disp_r |=> frame_r == spc_frame_t'(4'h0))
    else $error("standalone framing not 8N1");
  dial_ignore_a: assert property (disp_r && pset_r |=> baud_idx_r == $past(act_baud))
    else $error("dial not ignored");
  cancel_keep_a: assert property (pan_cancel |=> pend_r == $past(act_r) && $stable(act_r))
    else $error("cancel changed settings");
  mode_pass_a: assert property (cmd_rx && b == `SPC_C_MODE_HI |=> mode_r == 2'd3 && rq_r && rq_kind_r == RP_PASS)
    else $error("mode command not acknowledged");
  out_silent_a: assert property (cmd_rx && b >= `SPC_C_OUT_LO && b <= `SPC_C_OUT_HI |=> !rq_r)
    else $error("output code acknowledged");
  gain_dec_a: assert property (cmd_rx && !addsub_r && b == `SPC_C_GAIN_HI |=> gain_r == 3'd4)
    else $error("gain decode wrong");
  avg_dec_a: assert property (cmd_rx && b == `SPC_C_AVG_LO + 8'h02 |=> avg_r == 5'd2)
    else $error("averaging decode wrong");
  lock_set_a: assert property (cmd_rx && b == `SPC_C_LOCK_ON |=> lock_r ##1 lock_led)
    else $error("lock not set");
  lock_keys_a: assert property (lock_r && pan_wr |=> $stable(pend_r) && $stable(act_r))
    else $error("keys not locked");
  range_err_a: assert property (st_r == ST_VAL && ser.rx_valid && b == `SPC_CH_CR &&
    !range_ok(item_r, neg_r, acc_r, ovf_r) |=> rq_r && rq_kind_r == RP_ERROR)
    else $error("bad value accepted");
  addsub_gain_a: assert property (cmd_rx && addsub_r && b == `SPC_C_GAIN_LO |=> $stable(gain_r) && rq_kind_r == RP_ERROR)
    else $error("gain changed in add/sub");
  filt_disp_a: assert property (cmd_rx && !disp_r && b == `SPC_C_FILT_ON |=> $stable(filt_r))
    else $error("filter changed standalone");
  dtr_hold_a: assert property (!dtr && rp_busy_r |=> $stable(rp_idx_r))
    else $error("sent without terminal ready");
  unknown_a: assert property (cmd_rx && b == 8'h7E |=> !rq_r && st_r == ST_CMD)
    else $error("unknown code answered");
endmodule: spc_top

/* File: logic/spc_uart_rx.sv */
// Serial character receiver, mid-bit sampling
`timescale 1ns/10ps
module spc_uart_rx
  import spc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rxd,
  spc_ser_if.rx ser
);
  logic busy_r, busy_nxt, vld_r, vld_nxt;
  logic [19:0] cnt_r, cnt_nxt;
  logic [3:0] bit_r, bit_nxt, nd, last;
  logic [7:0] sh_r, sh_nxt, dat_r, dat_nxt;
  always_comb begin
    {busy_nxt, cnt_nxt, bit_nxt, sh_nxt, dat_nxt} = {busy_r, cnt_r, bit_r, sh_r, dat_r};
    vld_nxt = 1'b0;
    nd = ser.frame.seven ? 4'd7 : 4'd8;
    last = nd + {3'd0, ser.frame.par_en} + 4'd1;
    if (!busy_r) begin
      if (!rxd) begin
        busy_nxt = 1'b1;
        cnt_nxt = {1'b0, ser.div[19:1]};
        bit_nxt = 4'd0;
      end
    end else if (cnt_r > 20'd1) begin
      cnt_nxt = cnt_r - 20'd1;
    end else begin
      cnt_nxt = ser.div;
      bit_nxt = bit_r + 4'd1;
      if (bit_r == 4'd0 && rxd) busy_nxt = 1'b0;
      if (bit_r != 4'd0 && bit_r <= nd) sh_nxt = {rxd, sh_r[7:1]};
      if (bit_r == last) begin
        busy_nxt = 1'b0;
        vld_nxt = rxd;
        dat_nxt = ser.frame.seven ? {1'b0, sh_r[7:1]} : sh_r;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {busy_r, vld_r, cnt_r, bit_r, sh_r, dat_r} <= '0;
    end else begin
      {busy_r, vld_r, cnt_r, bit_r, sh_r, dat_r} <= {busy_nxt, vld_nxt, cnt_nxt, bit_nxt, sh_nxt, dat_nxt};
    end
  end
  assign ser.rx_valid = vld_r;
  assign ser.rx_data = dat_r;
endmodule: spc_uart_rx

/* File: logic/spc_uart_tx.sv */
// Serial character transmitter
`timescale 1ns/10ps
module spc_uart_tx
  import spc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  spc_ser_if.tx ser,
  output logic txd
);
  logic busy_r, busy_nxt, txd_r, txd_nxt, par;
  logic [19:0] cnt_r, cnt_nxt;
  logic [3:0] bit_r, bit_nxt, nb_r, nb_nxt;
  logic [11:0] sh_r, sh_nxt;
  always_comb begin
    {busy_nxt, txd_nxt, cnt_nxt, bit_nxt, nb_nxt, sh_nxt} = {busy_r, txd_r, cnt_r, bit_r, nb_r, sh_r};
    par = ^(ser.frame.seven ? {1'b0, ser.tx_data[6:0]} : ser.tx_data) ^ ser.frame.par_odd;
    if (!busy_r) begin
      txd_nxt = 1'b1;
      if (ser.tx_valid) begin
        busy_nxt = 1'b1;
        sh_nxt = {2'h3, 1'b1, ser.tx_data, 1'b0};
        if (ser.frame.seven) sh_nxt[8] = 1'b1;
        if (ser.frame.par_en) sh_nxt[ser.frame.seven ? 4'd8 : 4'd9] = par;
        nb_nxt = 4'd10 - {3'd0, ser.frame.seven} + {3'd0, ser.frame.par_en} + {3'd0, ser.frame.two_stop};
        cnt_nxt = ser.div;
        bit_nxt = 4'd0;
        txd_nxt = 1'b0;
      end
    end else if (cnt_r > 20'd1) begin
      cnt_nxt = cnt_r - 20'd1;
    end else begin
      cnt_nxt = ser.div;
      bit_nxt = bit_r + 4'd1;
      sh_nxt = {1'b1, sh_r[11:1]};
      txd_nxt = sh_r[1];
      if (bit_r + 4'd1 == nb_r) busy_nxt = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {busy_r, cnt_r, bit_r, nb_r, sh_r} <= '0;
      txd_r <= 1'b1;
    end else begin
      {busy_r, txd_r, cnt_r, bit_r, nb_r, sh_r} <= {busy_nxt, txd_nxt, cnt_nxt, bit_nxt, nb_nxt, sh_nxt};
    end
  end
  assign ser.tx_ready = !busy_r;
  assign txd = txd_r;
endmodule: spc_uart_tx

/* File: sim/spc_host_model.sv */
// Host computer model on the serial link
`timescale 1ns/10ps
module spc_host_model #(parameter int DIV = 20) (
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] rq[$];
  logic [7:0] b;
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] c);
    for (int i = 0; i < 10; i++) begin
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i-1];
      repeat (DIV) @(posedge pclk);
    end
  endtask: send
  initial begin
    forever begin
      @(negedge txd);
      repeat (DIV / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge pclk);
        b[i] = txd;
      end
      repeat (DIV) @(posedge pclk);
      if (txd === 1'b1) rq.push_back(b);
    end
  end
endmodule: spc_host_model

/* File: sim/spc_top_bench.sv */
// Self-checking bench for the command interpreter
`timescale 1ns/10ps
module spc_top_bench;
  localparam int DIV = 20;
  logic pclk, presetn, psel, penable, pwrite, dtr, err, pready, pslverr, rxd, txd, lock_led;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, prdata;
  logic [3:0] baud_dial;
  int error_cnt = 0;
  int total_checks = 0;
  spc_top #(.CLK_HZ(32'h0005_DC00)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .dtr(dtr), .baud_dial(baud_dial), .lock_led(lock_led));
  spc_host_model #(.DIV(DIV)) h (.pclk(pclk), .txd(txd), .rxd(rxd));
  task automatic final_report;
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask: final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask: chk
  task automatic rw(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e, input logic ee);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
    if (n >= 50) final_report();
    if (!w) chk(rd, e);
    chk({31'h0, err}, {31'h0, ee});
  endtask: rw
  task automatic reply(input string s);
    int n;
    n = 0;
    while (h.rq.size() < s.len() && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 4000) chk(32'h0000_0000, 32'h0000_0001);
    if (n >= 4000) final_report();
    foreach (s[i]) chk({24'h0, h.rq.pop_front()}, {24'h0, s[i]});
    repeat (15 * DIV) @(posedge pclk);
    chk(h.rq.size(), 32'h0000_0000);
  endtask: reply
  task automatic cmd(input string c, input string r);
    foreach (c[i]) h.send(c[i]);
    reply(r);
  endtask: cmd
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    dtr = 1'b1;
    baud_dial = 4'h9;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, txd}, 32'h0000_0001);
    rw(8'h08, 1'b0, 32'h0, 32'h0100_0000, 1'b0);
    rw(8'h10, 1'b0, 32'h0, 32'h0000_0000, 1'b1);
    cmd("(", "PASS\r");
    cmd("+", "PASS\r");
    rw(8'h08, 1'b0, 32'h0, 32'h0100_0058, 1'b0);
    cmd("M", "");
    cmd("~", "");
    cmd("A", "ERROR\r");
    rw(8'h00, 1'b1, 32'h1, 32'h0, 1'b0);
    rw(8'h04, 1'b1, 32'h5, 32'h0, 1'b0);
    rw(8'h04, 1'b1, 32'h200, 32'h0, 1'b0);
    rw(8'h04, 1'b0, 32'h0, 32'h0000_0004, 1'b0);
    rw(8'h04, 1'b1, 32'h108, 32'h0, 1'b0);
    baud_dial <= 4'h0;
    rw(8'h08, 1'b0, 32'h0, 32'h0100_0058, 1'b0);
    cmd("A", "PASS\r");
    cmd("p", "PASS\r");
    cmd("f", "ERROR\r");
    cmd(" ", "ERROR\r");
    cmd("n", "PASS\r");
    cmd("$", "PASS\r");
    cmd("f", "PASS\r");
    cmd("0.8000\r", "ERROR\r");
    cmd("f", "PASS\r");
    cmd("1.0500\r", "PASS\r");
    rw(8'h64, 1'b0, 32'h0, 32'h0000_2904, 1'b0);
    cmd("e", "PASS\r");
    cmd("-12\r", "PASS\r");
    rw(8'h60, 1'b0, 32'h0, 32'h8000_000C, 1'b0);
    cmd("g", "PASS\r");
    cmd("200\r", "PASS\r");
    cmd("i", "PASS\r");
    cmd("100\r", "PASS\r");
    rw(8'h68, 1'b0, 32'h0, 32'h0000_00C8, 1'b0);
    rw(8'h70, 1'b0, 32'h0, 32'h0000_0064, 1'b0);
    dtr <= 1'b0;
    cmd("?", "");
    chk({31'h0, lock_led}, 32'h0000_0001);
    rw(8'h0C, 1'b0, 32'h0, 32'h0000_000E, 1'b0);
    dtr <= 1'b1;
    reply("PASS\r");
    rw(8'h04, 1'b1, 32'h5, 32'h0, 1'b0);
    rw(8'h04, 1'b0, 32'h0, 32'h0000_0008, 1'b0);
    final_report();
  end
endmodule: spc_top_bench
